/* File: hdl/urt_pkg.sv */
`default_nettype none
package urt_pkg;
    // ***************************************************************
    // divisor, prescaler and frame constants
    // ***************************************************************
    localparam logic [7:0] DIV_MIN        = 8'h04;
    localparam logic [3:0] PRESCALE_MAX   = 4'ha;
    localparam logic [8:0] LATCH_MARGIN   = 9'h002;
    localparam logic [8:0] STOP_STRETCH   = 9'h002;
    localparam logic [3:0] RX_LAST_PARITY = 4'h9;
    localparam logic [3:0] RX_LAST_PLAIN  = 4'h8;
    localparam logic [3:0] TX_LAST_PARITY = 4'ha;
    localparam logic [3:0] TX_LAST_PLAIN  = 4'h9;
    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [7:0] RST_DATA       = 8'h00;
    localparam logic [9:0] RST_PRESCALE   = 10'h000;
    localparam logic [8:0] RST_COUNT      = 9'h000;
    localparam logic [3:0] RST_BITS       = 4'h0;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} urt_rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_STRETCH} urt_tx_state_t;
endpackage : urt_pkg
`default_nettype wire

/* File: hdl/urt_base_clk.sv */
`default_nettype none
module urt_base_clk
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic       power_i,
    input  wire logic [3:0] select_i,
    output logic            tick_o
);
    logic [3:0] m_eff;
    logic [9:0] mask;
    logic [9:0] cnt;

    // RULE15 - clamp prescaler select
    assign m_eff = (select_i > urt_pkg::PRESCALE_MAX) ? urt_pkg::PRESCALE_MAX : select_i;
    assign mask  = 10'((11'h001 << m_eff) - 11'h001);
    // RULE15 - base tick every 2^m clocks
    assign tick_o = run_i && power_i && ((cnt & mask) == mask);

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt <= urt_pkg::RST_PRESCALE;
        else if (run_i && !power_i)
            cnt <= urt_pkg::RST_PRESCALE;
        else if (run_i)
            cnt <= cnt + 10'h001;
    end

    // RULE15 - select never exceeds ten
    a_prescale_range: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE15
        m_eff <= urt_pkg::PRESCALE_MAX) else $error("prescaler out of range");
    // RULE15 - m of two ticks every fourth clock
    a_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE15
        tick_o && m_eff == 4'h2 |=> (!tick_o || m_eff != 4'h2) [*3])
        else $error("base tick spacing wrong");
endmodule : urt_base_clk
`default_nettype wire

/* File: hdl/urt_core.sv */
// Notes on behaviour
// RULE1 - divisor-loaded counter times each received bit
// RULE2 - data latch carries two base clock margin
// RULE3 - eleven-bit frames tolerate the stated rate window
// RULE4 - sender rate error must stay within tolerance
// RULE5 - back-to-back frames stretch stop two clocks
// RULE6 - every start bit restarts receive timing
// RULE7 - clock withdrawn freezes registers and transmit pin
// RULE8 - software reinitializes by clearing power and enables
// RULE9 - errors only in status, no interrupt
// RULE10 - software polls status during or after DMA
// RULE11 - start: power, ports, then both enables
// RULE12 - stop: enables off, then ports, power
// RULE13 - every enabled transmit write starts a frame; here a write while tx_pend is set only replaces tx_hold, unless the pending frame starts that cycle
// RULE14 - rate is base over twice divisor, min 4
// RULE15 - base clock is main over 2^m, m<=10
// RULE16 - stop bit low flags framing error
`default_nettype none
module urt_core
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       clock_supply_i,
    input  wire logic       channel_power_bit_i,
    input  wire logic       transmit_enable_bit_i,
    input  wire logic       receive_enable_bit_i,
    input  wire logic       parity_enable_i,
    input  wire logic       parity_odd_i,
    input  wire logic [3:0] prescaler_select_register_i,
    input  wire logic [7:0] baud_divisor_register_i,
    input  wire logic       transmit_write_i,
    input  wire logic [7:0] transmit_data_register_i,
    input  wire logic       receive_read_i,
    input  wire logic       error_clear_i,
    input  wire logic       serial_receive_pin_i,
    output logic            serial_transmit_pin_o,
    output logic            transmit_busy_o,
    output logic [7:0]      receive_data_o,
    output logic            receive_valid_o,
    output logic            receive_full_o,
    output logic            parity_error_o,
    output logic            framing_error_o,
    output logic            overrun_error_o
);
    // ***************************************************************
    // clocking and divisor
    // ***************************************************************
    logic       run;
    logic       tick;
    logic [7:0] k_eff;
    logic [8:0] full_load;
    logic [8:0] first_load;

    // RULE7 - nothing advances without clock supply
    assign run = clock_supply_i;
    // RULE14 - settings below four act as four
    assign k_eff      = (baud_divisor_register_i < urt_pkg::DIV_MIN) ? urt_pkg::DIV_MIN
                                                                     : baud_divisor_register_i;
    // RULE14 - one bit is twice the divisor
    assign full_load  = {k_eff, 1'b0};
    // RULE2 - first latch half bit plus margin
    assign first_load = {1'b0, k_eff} + urt_pkg::LATCH_MARGIN;

    urt_base_clk u_base_clk
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (run),
        .power_i   (channel_power_bit_i),
        .select_i  (prescaler_select_register_i),
        .tick_o    (tick)
    );

    // ***************************************************************
    // receive pin synchroniser
    // ***************************************************************
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end
        else if (run)
        begin
            rx_meta <= serial_receive_pin_i;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // ***************************************************************
    // receiver
    // ***************************************************************
    urt_pkg::urt_rx_state_t rx_state;
    logic [8:0] rx_cnt;
    logic [3:0] rx_bitn;
    logic [8:0] rx_shift;
    logic       rx_on;
    logic       rx_fall;
    logic       rx_sample;
    logic       rx_finish;
    logic [3:0] rx_last;

    assign rx_on     = run && channel_power_bit_i && receive_enable_bit_i;
    assign rx_fall   = rx_prev && !rx_sync;
    assign rx_sample = rx_on && tick && (rx_cnt == 9'h001);
    assign rx_last   = parity_enable_i ? urt_pkg::RX_LAST_PARITY : urt_pkg::RX_LAST_PLAIN;
    // RULE16 - stop bit is the last latch
    assign rx_finish = rx_sample && (rx_state == urt_pkg::RX_DATA) && (rx_bitn == rx_last);

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_state <= urt_pkg::RX_IDLE;
            rx_cnt   <= urt_pkg::RST_COUNT;
            rx_bitn  <= urt_pkg::RST_BITS;
            rx_shift <= 9'h1ff;
        end
        else if (!run)
            rx_state <= rx_state;
        else if (!rx_on)
            rx_state <= urt_pkg::RX_IDLE;
        else
        begin
            unique case (rx_state)
                urt_pkg::RX_IDLE:
                begin
                    // RULE6 - start edge reloads timing
                    if (rx_fall)
                    begin
                        rx_state <= urt_pkg::RX_START;
                        // RULE1 - counter loaded from divisor
                        rx_cnt   <= first_load;
                        rx_bitn  <= urt_pkg::RST_BITS;
                    end
                end
                urt_pkg::RX_START:
                begin
                    if (rx_sample)
                    begin
                        rx_state <= rx_sync ? urt_pkg::RX_IDLE : urt_pkg::RX_DATA;
                        rx_cnt   <= full_load;
                    end
                    else if (tick)
                        rx_cnt <= rx_cnt - 9'h001;
                end
                urt_pkg::RX_DATA:
                begin
                    // RULE3 - latch each bit once per bit time
                    if (rx_sample)
                    begin
                        rx_cnt  <= full_load;
                        rx_bitn <= rx_bitn + 4'h1;
                        if (rx_finish)
                            rx_state <= urt_pkg::RX_IDLE;
                        else
                            rx_shift <= {rx_sync, rx_shift[8:1]};
                    end
                    else if (tick)
                        rx_cnt <= rx_cnt - 9'h001;
                end
            endcase
        end
    end

    // ***************************************************************
    // receive data and error status
    // ***************************************************************
    logic [7:0] rx_word;
    logic       rx_par_bad;

    assign rx_word    = parity_enable_i ? rx_shift[7:0] : rx_shift[8:1];
    assign rx_par_bad = parity_enable_i && ((^rx_shift) != parity_odd_i);

    // RULE9 - errors kept only as status bits
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            receive_data_o  <= urt_pkg::RST_DATA;
            receive_valid_o <= 1'b0;
            receive_full_o  <= 1'b0;
            parity_error_o  <= 1'b0;
            framing_error_o <= 1'b0;
            overrun_error_o <= 1'b0;
        end
        else if (!run)
            receive_valid_o <= receive_valid_o;
        else if (!channel_power_bit_i)
        begin
            receive_valid_o <= 1'b0;
            receive_full_o  <= 1'b0;
            parity_error_o  <= 1'b0;
            framing_error_o <= 1'b0;
            overrun_error_o <= 1'b0;
        end
        else
        begin
            receive_valid_o <= rx_finish;
            if (rx_finish)
                receive_data_o <= rx_word;
            receive_full_o  <= rx_finish || (receive_full_o && !receive_read_i);
            parity_error_o  <= (rx_finish && rx_par_bad) || (parity_error_o && !error_clear_i);
            // RULE16 - low stop bit sets framing error
            framing_error_o <= (rx_finish && !rx_sync) || (framing_error_o && !error_clear_i);
            overrun_error_o <= (rx_finish && receive_full_o && !receive_read_i)
                               || (overrun_error_o && !error_clear_i);
        end
    end

    // ***************************************************************
    // transmitter
    // ***************************************************************
    urt_pkg::urt_tx_state_t tx_state;
    logic [10:0] tx_sr;
    logic [8:0]  tx_cnt;
    logic [3:0]  tx_bitn;
    logic [7:0]  tx_hold;
    logic        tx_pend;
    logic        tx_on;
    logic        tx_wr;
    logic        tx_bit_end;
    logic [3:0]  tx_last;

    assign tx_on      = channel_power_bit_i && transmit_enable_bit_i;
    // RULE13 - any enabled write, even same value
    assign tx_wr      = run && tx_on && transmit_write_i;
    assign tx_bit_end = tick && (tx_cnt == 9'h001);
    assign tx_last    = parity_enable_i ? urt_pkg::TX_LAST_PARITY : urt_pkg::TX_LAST_PLAIN;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_state              <= urt_pkg::TX_IDLE;
            tx_sr                 <= 11'h7ff;
            tx_cnt                <= urt_pkg::RST_COUNT;
            tx_bitn               <= urt_pkg::RST_BITS;
            tx_hold               <= urt_pkg::RST_DATA;
            tx_pend               <= 1'b0;
            serial_transmit_pin_o <= 1'b1;
            transmit_busy_o       <= 1'b0;
        end
        // RULE7 - transmit pin holds its last level
        else if (!run)
            serial_transmit_pin_o <= serial_transmit_pin_o;
        else if (!tx_on)
        begin
            tx_state              <= urt_pkg::TX_IDLE;
            tx_pend               <= 1'b0;
            serial_transmit_pin_o <= 1'b1;
            transmit_busy_o       <= 1'b0;
        end
        else
        begin
            transmit_busy_o <= (tx_state != urt_pkg::TX_IDLE) || tx_pend || tx_wr;
            if (tx_wr)
                tx_hold <= transmit_data_register_i;
            unique case (tx_state)
                urt_pkg::TX_IDLE:
                begin
                    serial_transmit_pin_o <= 1'b1;
                    if (tx_pend)
                    begin
                        tx_state              <= urt_pkg::TX_SHIFT;
                        tx_sr                 <= {2'b11, tx_hold, 1'b0};
                        tx_sr[9]              <= parity_enable_i ? (^tx_hold ^ parity_odd_i) : 1'b1;
                        tx_cnt                <= full_load;
                        tx_bitn               <= urt_pkg::RST_BITS;
                        serial_transmit_pin_o <= 1'b0;
                    end
                    tx_pend <= tx_wr;
                end
                urt_pkg::TX_SHIFT:
                begin
                    tx_pend <= tx_pend || tx_wr;
                    if (tx_bit_end)
                    begin
                        tx_cnt  <= full_load;
                        tx_bitn <= tx_bitn + 4'h1;
                        tx_sr   <= {1'b1, tx_sr[10:1]};
                        serial_transmit_pin_o <= tx_sr[1];
                        if (tx_bitn == tx_last)
                        begin
                            serial_transmit_pin_o <= 1'b1;
                            // RULE5 - queued frame stretches stop bit
                            if (tx_pend || tx_wr)
                            begin
                                tx_state <= urt_pkg::TX_STRETCH;
                                tx_cnt   <= urt_pkg::STOP_STRETCH;
                            end
                            else
                                tx_state <= urt_pkg::TX_IDLE;
                        end
                    end
                    else if (tick)
                        tx_cnt <= tx_cnt - 9'h001;
                end
                urt_pkg::TX_STRETCH:
                begin
                    // RULE5 - next start right after stretch
                    if (tx_bit_end)
                    begin
                        tx_state              <= urt_pkg::TX_SHIFT;
                        tx_sr                 <= {2'b11, tx_hold, 1'b0};
                        tx_sr[9]              <= parity_enable_i ? (^tx_hold ^ parity_odd_i) : 1'b1;
                        tx_cnt                <= full_load;
                        tx_bitn               <= urt_pkg::RST_BITS;
                        serial_transmit_pin_o <= 1'b0;
                        tx_pend               <= tx_wr;
                    end
                    else
                    begin
                        tx_pend <= tx_pend || tx_wr;
                        if (tick)
                            tx_cnt <= tx_cnt - 9'h001;
                    end
                end
            endcase
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    sequence s_tx_write_idle;
        run && tx_on && transmit_write_i && tx_state == urt_pkg::TX_IDLE && !tx_pend;
    endsequence

    sequence s_tx_frame_begins;
        tx_pend ##1 (tx_state == urt_pkg::TX_SHIFT && !serial_transmit_pin_o);
    endsequence

    a_write_starts: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
        s_tx_write_idle |=> s_tx_frame_begins) else $error("write did not start frame");

    a_divisor_floor: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE14
        full_load >= 9'h008) else $error("bit time below minimum");

    a_freeze_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
        !run |=> $stable(serial_transmit_pin_o) && $stable(tx_state) && $stable(rx_state)
                 && $stable(receive_data_o)) else $error("state moved without clock");

    a_error_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE9
        $rose(framing_error_o) || $rose(parity_error_o) |-> $past(rx_finish))
        else $error("error set outside frame end");

    a_framing_set: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE16
        rx_finish && !rx_sync && channel_power_bit_i |=> framing_error_o)
        else $error("low stop bit not flagged");

    a_stretch_high: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE5
        tx_state == urt_pkg::TX_SHIFT ##1 tx_state == urt_pkg::TX_STRETCH
        |-> serial_transmit_pin_o && tx_cnt == urt_pkg::STOP_STRETCH)
        else $error("stop stretch wrong");

    a_start_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
        rx_on && rx_state == urt_pkg::RX_IDLE && rx_fall
        |=> rx_state == urt_pkg::RX_START && rx_cnt == $past(first_load))
        else $error("start did not reload timing");

    a_bit_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
        rx_sample && rx_state == urt_pkg::RX_DATA && !rx_finish && run
        |=> rx_cnt == $past(full_load)) else $error("bit counter not reloaded");
endmodule : urt_core
`default_nettype wire

/* File: tb/urt_remote.sv */
`default_nettype none
module urt_remote
(
    input  wire logic tx_line_i,
    output logic      rx_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************************
    // far side sender and receiver
    // ***************************************************************
    real        bit_ns = 80.0;
    realtime    t_prev = 0;
    realtime    t_last = 0;
    logic [7:0] got    = 8'h00;
    int         frames = 0;
    initial rx_line_o = 1'b1;
    // caller keeps rate error inside tolerance
    task automatic send(input logic [7:0] d, input logic par_on, input logic pv,
                        input logic sv, input real p);
        rx_line_o <= 1'b0;
        #(p);
        for (int i = 0; i < 8; i++)
        begin
            rx_line_o <= d[i];
            #(p);
        end
        if (par_on)
        begin
            rx_line_o <= pv;
            #(p);
        end
        rx_line_o <= sv;
        #(p);
        rx_line_o <= 1'b1;
        #(p);
    endtask : send
    // sample mid-bit, note start times
    always @(negedge tx_line_i)
    begin
        t_prev = t_last;
        t_last = $realtime;
        #(bit_ns * 1.5);
        for (int i = 0; i < 8; i++)
        begin
            got[i] = tx_line_i;
            #(bit_ns);
        end
        frames++;
    end
endmodule : urt_remote
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************************
    // stimulus and checks
    // ***************************************************************
    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       supply    = 1'b1;
    logic       power     = 1'b0;
    logic       tx_en     = 1'b0;
    logic       rx_en     = 1'b0;
    logic       par_en    = 1'b0;
    logic       par_odd   = 1'b0;
    logic [3:0] presc     = 4'h0;
    logic [7:0] divisor   = 8'h04;
    logic       tx_wr     = 1'b0;
    logic [7:0] tx_data   = 8'h00;
    logic       rx_rd     = 1'b0;
    logic       err_clr   = 1'b0;
    logic       rx_pin, tx_pin, busy, rx_valid, rx_full, perr, ferr, oerr;
    logic [7:0] rx_data;
    logic [1:0] held;
    int         errors   = 0;
    int         compares = 0;
    int         moved    = 0;
    realtime    gap;
    always #5 sys_clk_i = ~sys_clk_i;
    urt_core i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clock_supply_i(supply),
        .channel_power_bit_i(power), .transmit_enable_bit_i(tx_en),
        .receive_enable_bit_i(rx_en), .parity_enable_i(par_en), .parity_odd_i(par_odd),
        .prescaler_select_register_i(presc), .baud_divisor_register_i(divisor),
        .transmit_write_i(tx_wr), .transmit_data_register_i(tx_data),
        .receive_read_i(rx_rd), .error_clear_i(err_clr), .serial_receive_pin_i(rx_pin),
        .serial_transmit_pin_o(tx_pin), .transmit_busy_o(busy), .receive_data_o(rx_data),
        .receive_valid_o(rx_valid), .receive_full_o(rx_full), .parity_error_o(perr),
        .framing_error_o(ferr), .overrun_error_o(oerr));
    urt_remote i_remote (.tx_line_i(tx_pin), .rx_line_o(rx_pin));
    task automatic close_out();
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc
    task automatic write_tx(input logic [7:0] d);
        @(posedge sys_clk_i);
        tx_wr   <= 1'b1;
        tx_data <= d;
        @(posedge sys_clk_i);
        tx_wr   <= 1'b0;
    endtask : write_tx
    task automatic pulse_rd();
        @(posedge sys_clk_i);
        rx_rd <= 1'b1;
        @(posedge sys_clk_i);
        rx_rd <= 1'b0;
    endtask : pulse_rd
    task automatic hang(input string msg);
        errors++;
        $display("[FAIL] %0t %s timed out", $time, msg);
        close_out();
    endtask : hang
    task automatic wait_idle();
        int n;
        for (n = 0; n < 20000; n++)
        begin
            @(negedge sys_clk_i);
            if (busy === 1'b0)
                break;
        end
        if (n == 20000)
            hang("transmit");
    endtask : wait_idle
    task automatic wait_valid();
        int n;
        for (n = 0; n < 20000; n++)
        begin
            @(negedge sys_clk_i);
            if (rx_valid === 1'b1)
                break;
        end
        if (n == 20000)
            hang("receive");
    endtask : wait_valid
    task automatic rx_frame(input logic [7:0] d, input logic pv, input logic sv, input real p);
        fork
            i_remote.send(d, par_en, pv, sv, p);
            wait_valid();
        join
    endtask : rx_frame
    initial
    begin
        cyc(16);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        check({perr, ferr, oerr, busy, rx_valid}, 0, "after reset");
        write_tx(8'h55);
        cyc(3);
        check(busy, 0, "write while off");
        power <= 1'b1;
        cyc(2);
        tx_en <= 1'b1;
        rx_en <= 1'b1;
        cyc(2);
        write_tx(8'ha5);
        write_tx(8'ha5);
        wait_idle();
        cyc(20);
        gap = i_remote.t_last - i_remote.t_prev;
        check(i_remote.got, 8'ha5, "same byte twice");
        check(i_remote.frames, 2, "two frames sent");
        check(gap == 820, 1, "stretched stop");
        presc <= 4'h2;
        i_remote.bit_ns = 320.0;
        write_tx(8'h3c);
        write_tx(8'hc3);
        wait_idle();
        cyc(80);
        gap = i_remote.t_last - i_remote.t_prev;
        check(i_remote.got, 8'hc3, "prescaled byte");
        check(i_remote.frames, 4, "prescaled frames sent");
        // first start is not tick aligned, so up to one base clock short
        check(gap >= 3250 && gap <= 3280, 1, "prescaled frame");
        presc   <= 4'h0;
        divisor <= 8'h14;
        par_en  <= 1'b1;
        par_odd <= 1'b1;
        cyc(4);
        rx_frame(8'h3c, 1'b1, 1'b1, 400.0 / 1.03);
        check({rx_data, perr, ferr}, {8'h3c, 2'b00}, "fast sender");
        pulse_rd();
        rx_frame(8'h96, 1'b1, 1'b1, 400.0 / 0.96);
        check({rx_data, perr, ferr}, {8'h96, 2'b00}, "slow sender");
        pulse_rd();
        rx_frame(8'h3c, 1'b0, 1'b1, 400.0);
        check(perr, 1, "bad parity");
        pulse_rd();
        rx_frame(8'h5a, 1'b1, 1'b0, 400.0);
        check(ferr, 1, "stop low");
        pulse_rd();
        @(posedge sys_clk_i);
        err_clr <= 1'b1;
        @(posedge sys_clk_i);
        err_clr <= 1'b0;
        @(negedge sys_clk_i);
        check({perr, ferr, oerr}, 0, "flags cleared");
        rx_frame(8'h11, 1'b1, 1'b1, 400.0);
        rx_frame(8'h77, 1'b1, 1'b1, 400.0);
        check({rx_data, oerr}, {8'h77, 1'b1}, "second frame unread");
        check({perr, ferr}, 2'b00, "status polled");
        divisor <= 8'h04;
        par_en  <= 1'b0;
        i_remote.bit_ns = 80.0;
        write_tx(8'h0f);
        cyc(20);
        supply <= 1'b0;
        @(negedge sys_clk_i);
        held = {tx_pin, busy};
        repeat (40)
        begin
            @(negedge sys_clk_i);
            if ({tx_pin, busy} !== held)
                moved++;
        end
        check(moved, 0, "frozen outputs");
        supply <= 1'b1;
        // clear power and both enables after resume
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        cyc(2);
        power <= 1'b0;
        cyc(3);
        @(negedge sys_clk_i);
        check({tx_pin, busy}, 2'b10, "reinitialized");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
